// *** hvtid_pkg.sv ***
package hvtid_pkg;

  // ****************************************
  // Register indices (no offsets are printed)
  // ****************************************
  localparam logic [2:0] HVTID_IDX_HYP_CONFIG  = 3'h0;
  localparam logic [2:0] HVTID_IDX_FAULT_IPA   = 3'h1;
  localparam logic [2:0] HVTID_IDX_DEBUG_ID0   = 3'h2;
  localparam logic [2:0] HVTID_IDX_ISA_ID0     = 3'h3;
  localparam logic [2:0] HVTID_IDX_ISA_ID1     = 3'h4;

  // ****************************************
  // Hypervisor configuration field positions
  // ****************************************
  localparam int HVTID_GE_TRAP_BIT   = 27;
  localparam int HVTID_ID3_TRAP_BIT  = 18;
  localparam int HVTID_ID0_TRAP_BIT  = 15;
  localparam int HVTID_SETWAY_BIT    = 1;
  localparam int HVTID_FIQ_ROUTE_BIT = 3;
  localparam int HVTID_IRQ_ROUTE_BIT = 4;
  localparam int HVTID_SER_ROUTE_BIT = 5;

  // Bits software may change; everything else is fixed
  localparam logic [63:0] HVTID_HCR_RW_MASK = 64'h0000_0000_0804_8038;
  localparam logic [63:0] HVTID_HCR_ONES    = 64'h0000_0000_0000_0002;
  // Value loaded at reset; architecturally unknown, kept 0x2 here (only fixed bit 1 set)
  localparam logic [63:0] HVTID_HCR_RESET   = 64'h0000_0000_0000_0002;

  // ****************************************
  // Fault address layout
  // ****************************************
  localparam int HVTID_FAULT_IPA_FIELD_LSB     = 4;
  localparam int HVTID_FAULT_IPA_FIELD_MSB     = 39;
  localparam int HVTID_IPA_LSB      = 12;
  localparam int HVTID_IPA_MSB      = 47;
  localparam logic [35:0] HVTID_FAULT_IPA_FIELD_RESET = 36'h0_0000_0000;

  // ****************************************
  // Identification values
  // ****************************************
  localparam logic [63:0] HVTID_DEBUG_ID0_VAL = 64'h0000_0000_1030_5408;
  localparam logic [63:0] HVTID_ISA_ID0_BASE  = 64'h0000_1000_1021_0000;
  localparam logic [63:0] HVTID_ISA_ID0_CRYPT = 64'h0000_0000_0000_1120;
  localparam logic [63:0] HVTID_ISA_ID1_VAL   = 64'h0000_0000_0010_0001;

endpackage

// *** hvtid_regs.sv ***
// What this block does
// - Bit 27 holds general-exception trap; effective only with non-secure state.
// - Effective trap reroutes exceptions aimed at level 1 to level 2.
// - Effective trap forces stage-1 MMU enable to 0; reads see stored value.
// - Effective trap forces FIQ, IRQ, SError routing to 1; reads unchanged.
// - Effective trap disables all virtual interrupt signalling.
// - Effective trap makes exception return to level 1 illegal.
// - Trap bit is never cached; lookups use the live value.
// - Secure state makes the trap bit act as 0 except direct access.
// - Bit 18 set traps non-secure level-1 group-3 ID reads to level 2.
// - Bit 15 traps fp and bytecode ID reads from levels 1/0; secure gates.
// - Bit 1 fixed at 1; set/way invalidate becomes clean-and-invalidate.
// - Without level 2, configuration and fault registers read zero, ignore writes.
// - Writable fields have no defined reset value to rely on.
// - Stage-2 aborts taken to level 2 capture the faulting IPA.
// - IPA bits 47:12 sit in 39:4; other bits read zero.
// - Debug ID reports 0x1, 0x3, 0x5 count fields.
// - Debug ID reports perfmon 0x4, trace 0x0, debug arch 0x8.
// - Three ID registers are read-only 64-bit constants, reserved zero.
// - ISA ID0 reports dot-product 0x1 and rounding MAC 0x1.
// - ISA ID0 reports atomics 0x2 and CRC32 0x1.
// - Crypto fields read 0 without option, else 0x1, 0x1, 0x2.
// - ISA ID1 reports acquire-pc load 0x1 and persist clean 0x1.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module hvtid_regs
  import hvtid_pkg::*;
#(
  parameter bit EL2_PRESENT   = 1'b1,
  parameter bit CRYPTO_OPTION = 1'b0
) (
  input  wire logic        clk,               // Core clock
  input  wire logic        sys_rst,           // Synchronous reset, active high
  input  wire logic [2:0]  regAddr,           // Register index
  input  wire logic [63:0] regWdata,          // Write data
  input  wire logic        regWr,             // Write strobe
  input  wire logic        regRd,             // Read strobe
  output logic      [63:0] regRdata,          // Read data, cycle after strobe
  input  wire logic        nonsecureState,    // Security state, 1 = non-secure
  input  wire logic        stage1MmuEnable,   // Stored stage-1 MMU enable
  input  wire logic        s2AbortValid,      // Stage-2 abort taken to level 2
  input  wire logic [47:0] s2AbortIpa,        // Faulting IPA of that abort
  input  wire logic        excTargetsEl1,     // Pending exception aims at level 1
  input  wire logic        eretTargetsEl1,    // Exception return aims at level 1
  input  wire logic        idGroup3Read,      // Group-3 ID read at non-secure level 1
  input  wire logic        idGroup0Read,      // fp or bytecode ID read at level 1/0
  input  wire logic        setwayInval,       // Set/way invalidate at non-secure level 1
  output logic             excToEl2,          // Exception redirected to level 2
  output logic             mmuEnableEff,      // Effective stage-1 MMU enable
  output logic             fiqRouteEff,       // Effective FIQ routing
  output logic             irqRouteEff,       // Effective IRQ routing
  output logic             serrorRouteEff,    // Effective SError routing
  output logic             virtIrqEnable,     // Virtual interrupts permitted
  output logic             illegalEret,       // Exception return is illegal
  output logic             geTrapLive,        // Live trap value for lookups
  output logic             idGroup3Trap,      // Group-3 ID read traps
  output logic             idGroup0Trap,      // Group-0 ID read traps
  output logic             setwayClean        // Perform clean-and-invalidate
);

  // ****************************************
  // Register state
  // ****************************************
  logic [63:0] hypConfig_q;
  logic [63:0] hypConfig_d;
  logic [35:0] faultIpa_q;
  logic [35:0] faultIpa_d;
  logic [63:0] rdata_q;
  logic [63:0] rdata_d;
  logic [63:0] isaId0Val;
  logic [63:0] faultIpaWord;

  logic        geEff;
  logic        ctlExc_q,  ctlExc_d;
  logic        ctlMmu_q,  ctlMmu_d;
  logic        ctlFiq_q,  ctlFiq_d;
  logic        ctlIrq_q,  ctlIrq_d;
  logic        ctlSer_q,  ctlSer_d;
  logic        ctlVirq_q, ctlVirq_d;
  logic        ctlEret_q, ctlEret_d;
  logic        ctlLive_q, ctlLive_d;
  logic        ctlId3_q,  ctlId3_d;
  logic        ctlId0_q,  ctlId0_d;
  logic        ctlSw_q,   ctlSw_d;

  assign isaId0Val = CRYPTO_OPTION ? (HVTID_ISA_ID0_BASE | HVTID_ISA_ID0_CRYPT)
                                   : HVTID_ISA_ID0_BASE;

  assign faultIpaWord = {24'h00_0000, faultIpa_q, 4'h0};

  // ****************************************
  // Register writes and fault capture
  // ****************************************
  always_comb begin
    hypConfig_d = hypConfig_q;
    faultIpa_d  = faultIpa_q;
    if (regWr && regAddr == HVTID_IDX_HYP_CONFIG) begin
      hypConfig_d = (regWdata & HVTID_HCR_RW_MASK) | HVTID_HCR_ONES;
    end
    if (regWr && regAddr == HVTID_IDX_FAULT_IPA) begin
      faultIpa_d = regWdata[HVTID_FAULT_IPA_FIELD_MSB:HVTID_FAULT_IPA_FIELD_LSB];
    end
    // hardware capture wins over software write
    if (s2AbortValid) begin
      faultIpa_d = s2AbortIpa[HVTID_IPA_MSB:HVTID_IPA_LSB];
    end
    if (!EL2_PRESENT) begin
      hypConfig_d = 64'h0;
      faultIpa_d  = 36'h0;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    rdata_d = 64'h0;
    if (regRd) begin
      case (regAddr)
        HVTID_IDX_HYP_CONFIG: rdata_d = EL2_PRESENT ? hypConfig_q : 64'h0;
        HVTID_IDX_FAULT_IPA:  rdata_d = EL2_PRESENT ? faultIpaWord : 64'h0;
        HVTID_IDX_DEBUG_ID0:  rdata_d = HVTID_DEBUG_ID0_VAL;
        HVTID_IDX_ISA_ID0:    rdata_d = isaId0Val;
        HVTID_IDX_ISA_ID1:    rdata_d = HVTID_ISA_ID1_VAL;
        default:              rdata_d = 64'h0;
      endcase
    end
  end

  // ****************************************
  // Effective controls
  // ****************************************
  // gate by security state
  assign geEff = hypConfig_q[HVTID_GE_TRAP_BIT] & nonsecureState;

  always_comb begin
    ctlLive_d = geEff;
    ctlExc_d  = geEff & excTargetsEl1;
    ctlMmu_d  = stage1MmuEnable & ~geEff;
    ctlFiq_d  = hypConfig_q[HVTID_FIQ_ROUTE_BIT] | geEff;
    ctlIrq_d  = hypConfig_q[HVTID_IRQ_ROUTE_BIT] | geEff;
    ctlSer_d  = hypConfig_q[HVTID_SER_ROUTE_BIT] | geEff;
    ctlVirq_d = ~geEff;
    ctlEret_d = geEff & eretTargetsEl1;
    ctlId3_d  = hypConfig_q[HVTID_ID3_TRAP_BIT] & idGroup3Read;
    ctlId0_d  = hypConfig_q[HVTID_ID0_TRAP_BIT] & nonsecureState & idGroup0Read;
    ctlSw_d   = hypConfig_q[HVTID_SETWAY_BIT] & setwayInval;
  end

  // ****************************************
  // Registers
  // ****************************************
  // reset value is not architecturally defined
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hypConfig_q <= EL2_PRESENT ? HVTID_HCR_RESET : 64'h0;
      faultIpa_q  <= HVTID_FAULT_IPA_FIELD_RESET;
      rdata_q     <= 64'h0;
      ctlExc_q    <= 1'b0;
      ctlMmu_q    <= 1'b0;
      ctlFiq_q    <= 1'b0;
      ctlIrq_q    <= 1'b0;
      ctlSer_q    <= 1'b0;
      ctlVirq_q   <= 1'b0;
      ctlEret_q   <= 1'b0;
      ctlLive_q   <= 1'b0;
      ctlId3_q    <= 1'b0;
      ctlId0_q    <= 1'b0;
      ctlSw_q     <= 1'b0;
    end else begin
      hypConfig_q <= hypConfig_d;
      faultIpa_q  <= faultIpa_d;
      rdata_q     <= rdata_d;
      ctlExc_q    <= ctlExc_d;
      ctlMmu_q    <= ctlMmu_d;
      ctlFiq_q    <= ctlFiq_d;
      ctlIrq_q    <= ctlIrq_d;
      ctlSer_q    <= ctlSer_d;
      ctlVirq_q   <= ctlVirq_d;
      ctlEret_q   <= ctlEret_d;
      ctlLive_q   <= ctlLive_d;
      ctlId3_q    <= ctlId3_d;
      ctlId0_q    <= ctlId0_d;
      ctlSw_q     <= ctlSw_d;
    end
  end

  assign regRdata       = rdata_q;
  assign excToEl2       = ctlExc_q;
  assign mmuEnableEff   = ctlMmu_q;
  assign fiqRouteEff    = ctlFiq_q;
  assign irqRouteEff    = ctlIrq_q;
  assign serrorRouteEff = ctlSer_q;
  assign virtIrqEnable  = ctlVirq_q;
  assign illegalEret    = ctlEret_q;
  assign geTrapLive     = ctlLive_q;
  assign idGroup3Trap   = ctlId3_q;
  assign idGroup0Trap   = ctlId0_q;
  assign setwayClean    = ctlSw_q;

endmodule

`default_nettype wire

// *** hvtid_regs_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module hvtid_regs_assertions
  import hvtid_pkg::*;
(
  input wire logic        clk,             // Core clock
  input wire logic        sys_rst,         // Sync reset
  input wire logic [2:0]  regAddr,         // Index
  input wire logic        regRd,           // Read strobe
  input wire logic [63:0] regRdata,        // Read data
  input wire logic        nonsecureState,  // Security state
  input wire logic        stage1MmuEnable, // Stored MMU enable
  input wire logic        excTargetsEl1,   // Exception to 1
  input wire logic        eretTargetsEl1,  // Return to 1
  input wire logic        idGroup3Read,    // Group-3 read
  input wire logic        excToEl2,        // Rerouted
  input wire logic        mmuEnableEff,    // Effective MMU
  input wire logic        fiqRouteEff,     // FIQ routing
  input wire logic        irqRouteEff,     // IRQ routing
  input wire logic        serrorRouteEff,  // SError routing
  input wire logic        virtIrqEnable,   // Virtual irq on
  input wire logic        illegalEret,     // Illegal return
  input wire logic        geTrapLive,      // Live trap
  input wire logic        idGroup3Trap,    // Group-3 trap
  input wire logic        idGroup0Trap     // Group-0 trap
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****************************************
  // Trap effects and read values
  // ****************************************
  a_exc_reroute: assert property (!$past(sys_rst) |-> excToEl2 == (geTrapLive && $past(excTargetsEl1)))
    else $error("exception reroute wrong");
  a_mmu_forced: assert property (!$past(sys_rst) |-> mmuEnableEff == (!geTrapLive && $past(stage1MmuEnable)))
    else $error("mmu enable not forced");
  a_route_forced: assert property (geTrapLive |-> fiqRouteEff && irqRouteEff && serrorRouteEff)
    else $error("routing not forced");
  a_virt_off: assert property (!$past(sys_rst) |-> virtIrqEnable != geTrapLive)
    else $error("virtual irq not disabled");
  a_eret_illegal: assert property (!$past(sys_rst) |-> illegalEret == (geTrapLive && $past(eretTargetsEl1)))
    else $error("return legality wrong");
  a_secure_gate: assert property (!$past(nonsecureState) |-> !geTrapLive && !idGroup0Trap)
    else $error("secure state not gating");
  a_id3_cause: assert property (!$past(idGroup3Read) |-> !idGroup3Trap)
    else $error("group-3 trap without read");
  a_debug_const: assert property ($past(regRd) && $past(regAddr) == 3'h2 |-> regRdata == 64'h0000_0000_1030_5408)
    else $error("debug id value wrong");
  a_ipa_layout: assert property ($past(regRd) && $past(regAddr) == 3'h1 |-> regRdata[63:40] == 24'h0 && regRdata[3:0] == 4'h0)
    else $error("fault address reserved bits set");
  c_trap_on: cover property (geTrapLive && excToEl2);
  c_id0_trap: cover property (idGroup0Trap);
  c_eret_bad: cover property (illegalEret);
endmodule
bind hvtid_regs hvtid_regs_assertions u_hvtid_regs_assertions (.clk(clk), .sys_rst(sys_rst),
  .regAddr(regAddr), .regRd(regRd), .regRdata(regRdata), .nonsecureState(nonsecureState),
  .stage1MmuEnable(stage1MmuEnable), .excTargetsEl1(excTargetsEl1),
  .eretTargetsEl1(eretTargetsEl1), .idGroup3Read(idGroup3Read), .excToEl2(excToEl2),
  .mmuEnableEff(mmuEnableEff), .fiqRouteEff(fiqRouteEff), .irqRouteEff(irqRouteEff),
  .serrorRouteEff(serrorRouteEff), .virtIrqEnable(virtIrqEnable), .illegalEret(illegalEret),
  .geTrapLive(geTrapLive), .idGroup3Trap(idGroup3Trap), .idGroup0Trap(idGroup0Trap));
`default_nettype wire

// *** hvtid_regs_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module hvtid_regs_test
  import hvtid_pkg::*;
;
  logic        clk, sys_rst, regWr, regRd, nonsecureState, stage1MmuEnable, s2AbortValid;
  logic        excTargetsEl1, eretTargetsEl1, idGroup3Read, idGroup0Read, setwayInval;
  logic        excToEl2, mmuEnableEff, fiqRouteEff, irqRouteEff, serrorRouteEff, ge;
  logic        virtIrqEnable, illegalEret, geTrapLive, idGroup3Trap, idGroup0Trap, setwayClean;
  logic [2:0]  regAddr;
  logic [47:0] s2AbortIpa;
  logic [63:0] regWdata, regRdata, hcr, r;
  logic [63:0] regRdataAlt;
  int          num_errors, num_checks, seed;
  hvtid_regs u_hvtid_regs (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .nonsecureState(nonsecureState), .stage1MmuEnable(stage1MmuEnable),
    .s2AbortValid(s2AbortValid), .s2AbortIpa(s2AbortIpa), .excTargetsEl1(excTargetsEl1),
    .eretTargetsEl1(eretTargetsEl1), .idGroup3Read(idGroup3Read), .idGroup0Read(idGroup0Read),
    .setwayInval(setwayInval), .excToEl2(excToEl2), .mmuEnableEff(mmuEnableEff),
    .fiqRouteEff(fiqRouteEff), .irqRouteEff(irqRouteEff), .serrorRouteEff(serrorRouteEff),
    .virtIrqEnable(virtIrqEnable), .illegalEret(illegalEret), .geTrapLive(geTrapLive),
    .idGroup3Trap(idGroup3Trap), .idGroup0Trap(idGroup0Trap), .setwayClean(setwayClean));
  // Second build: no level 2, crypto option fitted
  hvtid_regs #(.EL2_PRESENT(1'b0), .CRYPTO_OPTION(1'b1)) u_hvtid_regs_alt (.clk(clk),
    .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdataAlt), .nonsecureState(nonsecureState), .stage1MmuEnable(stage1MmuEnable),
    .s2AbortValid(s2AbortValid), .s2AbortIpa(s2AbortIpa), .excTargetsEl1(excTargetsEl1),
    .eretTargetsEl1(eretTargetsEl1), .idGroup3Read(idGroup3Read), .idGroup0Read(idGroup0Read),
    .setwayInval(setwayInval), .excToEl2(), .mmuEnableEff(), .fiqRouteEff(), .irqRouteEff(),
    .serrorRouteEff(), .virtIrqEnable(), .illegalEret(), .geTrapLive(), .idGroup3Trap(),
    .idGroup0Trap(), .setwayClean());
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [63:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [63:0] exp, input string what);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 check(what, regRdata, exp);
  endtask
  task automatic ctl;
    repeat (2) @(posedge clk);
    #1 ge = hcr[27] & nonsecureState;
    check("trap", {63'h0, geTrapLive}, {63'h0, ge});
    check("exc", {63'h0, excToEl2}, {63'h0, ge & excTargetsEl1});
    check("mmu", {63'h0, mmuEnableEff}, {63'h0, stage1MmuEnable & ~ge});
    check("route", {61'h0, serrorRouteEff, irqRouteEff, fiqRouteEff}, {61'h0, hcr[5:3] | {3{ge}}});
    check("virt", {63'h0, virtIrqEnable}, {63'h0, ~ge});
    check("eret", {63'h0, illegalEret}, {63'h0, ge & eretTargetsEl1});
    check("id3", {63'h0, idGroup3Trap}, {63'h0, hcr[18] & idGroup3Read});
    check("id0", {63'h0, idGroup0Trap}, {63'h0, hcr[15] & nonsecureState & idGroup0Read});
    check("setway", {63'h0, setwayClean}, {63'h0, setwayInval});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(5000 * 50);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    seed = 79345;
    {sys_rst, regWr, regRd, regAddr, regWdata, s2AbortValid, s2AbortIpa} = '0;
    {nonsecureState, stage1MmuEnable, excTargetsEl1, eretTargetsEl1} = '0;
    {idGroup3Read, idGroup0Read, setwayInval} = '0;
    sys_rst = 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    // Fixed and reserved fields ignore writes; first pass all ones, second all zeros
    for (int i = 0; i < 14; i++) begin
      r = (i == 0) ? '1 : (i == 1) ? 64'h0 : {$random(seed), $random(seed)};
      wr(3'h0, r);
      hcr = (r & 64'h0000_0000_0804_8038) | 64'h0000_0000_0000_0002;
      rd(3'h0, hcr, "hyp config");
      @(posedge clk);
      {nonsecureState, stage1MmuEnable, excTargetsEl1, eretTargetsEl1, idGroup3Read,
       idGroup0Read, setwayInval} <= (i == 0) ? 7'h7f : 7'($random(seed));
      ctl();
    end
    for (int i = 0; i < 4; i++) begin
      r = {$random(seed), $random(seed)};
      @(posedge clk);
      s2AbortValid <= 1'b1;
      s2AbortIpa <= r[47:0];
      @(posedge clk);
      s2AbortValid <= 1'b0;
      rd(3'h1, {24'h0, r[47:12], 4'h0}, "abort ipa");
      wr(3'h1, ~r);
      rd(3'h1, ~r & 64'h0000_00ff_ffff_fff0, "written ipa");
    end
    for (int a = 2; a < 8; a++) wr(3'(a), '1);
    rd(3'h2, 64'h0000_0000_1030_5408, "debug id");
    rd(3'h3, 64'h0000_1000_1021_0000, "isa id0");
    rd(3'h4, 64'h0000_0000_0010_0001, "isa id1");
    rd(3'h6, 64'h0, "unmapped");
    wr(3'h0, '1);
    wr(3'h1, '1);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= 3'h0;
    @(posedge clk);
    regAddr <= 3'h1;
    #1 check("alt hyp config", regRdataAlt, 64'h0);
    @(posedge clk);
    regAddr <= 3'h3;
    #1 check("alt fault ipa", regRdataAlt, 64'h0);
    @(posedge clk);
    regRd <= 1'b0;
    #1 check("alt isa id0", regRdataAlt, 64'h0000_1000_1021_1120);
    tally_and_finish();
  end
endmodule
`default_nettype wire
